// File: chop_sequencer.sv
// Global chop conversion sequencer with excitation source control
//
// What this block does
// RL1: First chop period uses the rate table; later periods take half that count.
// RL2: Table counts are in modulator periods, so time scales with master clock.
// RL3: Start on a start pin rise or seventh falling edge of a start command.
// RL4: Settling delay is added twice per result; default is 28 modulator periods.
// RL5: Conversions repeat back to back with input polarity reversed after each.
// RL6: Output is the average of the last two opposite-polarity samples.
// RL7: Resettling after each swap makes the output rate lower than nominal.
// RL8: Host raises the settling delay field when external parts settle slowly.
// RL9: Magnitude field sets the output of both excitation sources.
// RL10: Each source follows its own route field; both may share a pin.
// RL11: Host enables the reference first; sources stay off without it.
// RL12: One bit in the data rate register turns global chop on or off.
// RL13: First sinc3 chop result arrives after about six conversions.
// RL14: In continuous mode an averaged result appears every half first period.
// RL15: A new trigger restarts with normal polarity and drops partial averages.
`timescale 1ns/1ps
`default_nettype none

module chop_sequencer #(
   parameter int COUNT_SHIFT = 0,
   parameter logic [7:0] START_OPCODE = 8'h08
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Link pins
   input wire logic start_pin,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   // Filter sample
   input wire logic [chop_seq_pkg::SAMPLE_W-1:0] filter_sample,
   // Analog controls
   output logic chop_invert,
   output logic [3:0] excitation_magnitude_field,
   output logic [3:0] source1_route_field,
   output logic [3:0] source2_route_field
);
   localparam int SW = chop_seq_pkg::SAMPLE_W;
   localparam int CW = chop_seq_pkg::CNT_W;

   function automatic logic [7:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx[5:0], 2'b00};
   endfunction

   // ==========================================================
   // Register bus slave
   logic [7:0] gain_q, rate_q, exc1_q, exc2_q, ctrl_q;
   logic [7:0] awaddr_q;
   logic aw_full_q, w_full_q, bvalid_q, rvalid_q, arready_q;
   logic [31:0] rdata_q;
   logic [1:0] bresp_q, rresp_q;
   logic soft_start_q, data_read_q;

   wire logic do_write = aw_full_q && w_full_q && !bvalid_q;
   wire logic wr_gain = do_write && awaddr_q == reg_addr(chop_seq_pkg::IDX_GAIN);
   wire logic wr_rate = do_write && awaddr_q == reg_addr(chop_seq_pkg::IDX_RATE);
   wire logic wr_exc1 = do_write && awaddr_q == reg_addr(chop_seq_pkg::IDX_EXC1);
   wire logic wr_exc2 = do_write && awaddr_q == reg_addr(chop_seq_pkg::IDX_EXC2);
   wire logic wr_ctrl = do_write && awaddr_q == reg_addr(chop_seq_pkg::IDX_CTRL);
   wire logic wr_hit = wr_gain || wr_rate || wr_exc1 || wr_exc2 || wr_ctrl;
   wire logic [7:0] wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
   wire logic do_read = s_axi_arvalid && arready_q;

   logic [7:0] wb_q;
   logic wb_en_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wb_q <= 8'h00;
         wb_en_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= chop_seq_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wb_q <= wbyte;
            wb_en_q <= s_axi_wstrb[0];
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? chop_seq_pkg::RESP_OKAY : chop_seq_pkg::RESP_SLVERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
         end
      end
   end

   // Only byte lane zero carries register bits; other lanes are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gain_q <= chop_seq_pkg::GAIN_RST;
         rate_q <= chop_seq_pkg::RATE_RST;
         exc1_q <= chop_seq_pkg::EXC1_RST;
         exc2_q <= chop_seq_pkg::EXC2_RST;
         ctrl_q <= chop_seq_pkg::CTRL_RST;
         soft_start_q <= 1'b0;
      end else begin
         if (wr_gain && wb_en_q) gain_q <= wb_q;
         // RL12 chop enable bit
         if (wr_rate && wb_en_q) rate_q <= wb_q;
         if (wr_exc1 && wb_en_q) exc1_q <= wb_q;
         if (wr_exc2 && wb_en_q) exc2_q <= wb_q;
         if (wr_ctrl && wb_en_q) ctrl_q <= wb_q & ~(8'h01 << chop_seq_pkg::SOFT_START_BIT);
         soft_start_q <= wr_ctrl && wb_en_q && wb_q[chop_seq_pkg::SOFT_START_BIT];
      end
   end

   // ==========================================================
   // Sequencer state
   chop_seq_pkg::seq_state_t state_q;
   logic pol_q, ready_q;
   logic signed [SW-1:0] prev_q, data_q;
   wire logic link_trig, tmr_done, tmr_run;
   wire logic trigger = link_trig || soft_start_q;
   wire logic gchop = rate_q[chop_seq_pkg::GCHOP_BIT];
   wire logic cont = rate_q[chop_seq_pkg::CONT_BIT];
   wire logic ref_en = ctrl_q[chop_seq_pkg::REFEN_BIT];

   // RL1 table lookup, scaled down for simulation
   wire logic [CW-1:0] first_w = chop_seq_pkg::first_mods(
      rate_q[chop_seq_pkg::RATE_LSB +: chop_seq_pkg::RATE_W]) >> COUNT_SHIFT;
   wire logic [CW-1:0] half_w = first_w >> 1;
   wire logic [CW-1:0] dly_w = chop_seq_pkg::delay_mods(
      gain_q[chop_seq_pkg::DELAY_LSB +: chop_seq_pkg::DELAY_W]);
   // RL4 delay twice per result with chop on, once with it off
   wire logic [CW-1:0] run_mods = CW'(half_w + dly_w + (gchop ? dly_w : '0));
   wire logic [CW-1:0] first_half_mods = CW'(half_w + dly_w);

   // RL6 positive-polarity sample minus inverted sample, halved
   wire logic signed [SW:0] cur_w = {filter_sample[SW-1], filter_sample};
   wire logic signed [SW:0] old_w = {prev_q[SW-1], prev_q};
   wire logic signed [SW:0] diff_w = pol_q ? (old_w - cur_w) : (cur_w - old_w);
   wire logic signed [SW-1:0] avg_w = SW'(diff_w >>> 1);

   // RL13 first result needs two settled half periods
   wire logic in_first = state_q == chop_seq_pkg::ST_FIRST;
   wire logic in_run = state_q == chop_seq_pkg::ST_RUN;
   wire logic result_w = tmr_done && in_run && !trigger;
   wire logic keep_on = cont || (in_first && gchop);
   wire logic tmr_load = trigger || (tmr_done && !trigger && keep_on && !(in_run && !cont));
   wire logic [CW-1:0] tmr_mods = (trigger && gchop) || in_first ? first_half_mods : run_mods;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= chop_seq_pkg::ST_IDLE;
         pol_q <= 1'b0;
         prev_q <= '0;
         data_q <= '0;
      end else if (trigger) begin
         // RL15 restart with normal polarity
         state_q <= gchop ? chop_seq_pkg::ST_FIRST : chop_seq_pkg::ST_RUN;
         pol_q <= 1'b0;
         prev_q <= '0;
      end else if (tmr_done && in_first) begin
         // RL6 first swap after first data
         prev_q <= filter_sample;
         pol_q <= 1'b1;
         state_q <= chop_seq_pkg::ST_RUN;
      end else if (result_w) begin
         // RL5 reverse polarity every conversion with chop on, hold normal polarity with it off
         pol_q <= gchop ? !pol_q : 1'b0;
         prev_q <= filter_sample;
         // RL14 averaged result each data cycle with chop on, raw sample with it off
         data_q <= gchop ? avg_w : filter_sample;
         if (!cont) state_q <= chop_seq_pkg::ST_IDLE;
      end
   end

   // Ready set wins over the clear caused by reading data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= result_w || (ready_q && !data_read_q);
      end
   end

   conv_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(tmr_load),
      .load_mods(tmr_mods),
      .running(tmr_run),
      .done(tmr_done)
   );

   trigger_capture #(
      .START_OPCODE(START_OPCODE)
   ) u_trig (
      .aclk(aclk),
      .aresetn(aresetn),
      .start_pin(start_pin),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .trigger(link_trig)
   );

   // ==========================================================
   // Read path
   wire logic [31:0] stat_w = {29'h0, pol_q, ready_q, tmr_run};
   wire logic [31:0] data_ext = {{(32 - SW){data_q[SW-1]}}, data_q};
   logic [31:0] rmux;
   logic rhit;
   always_comb begin
      rhit = 1'b1;
      case (s_axi_araddr)
         reg_addr(chop_seq_pkg::IDX_GAIN): rmux = {24'h0, gain_q};
         reg_addr(chop_seq_pkg::IDX_RATE): rmux = {24'h0, rate_q};
         reg_addr(chop_seq_pkg::IDX_EXC1): rmux = {24'h0, exc1_q};
         reg_addr(chop_seq_pkg::IDX_EXC2): rmux = {24'h0, exc2_q};
         reg_addr(chop_seq_pkg::IDX_CTRL): rmux = {24'h0, ctrl_q};
         reg_addr(chop_seq_pkg::IDX_STAT): rmux = stat_w;
         reg_addr(chop_seq_pkg::IDX_DATA): rmux = data_ext;
         default: begin
            rmux = 32'h0000_0000;
            rhit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= chop_seq_pkg::RESP_OKAY;
         data_read_q <= 1'b0;
      end else begin
         data_read_q <= do_read && s_axi_araddr == reg_addr(chop_seq_pkg::IDX_DATA);
         if (do_read) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rmux;
            rresp_q <= rhit ? chop_seq_pkg::RESP_OKAY : chop_seq_pkg::RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Analog control outputs
   logic [3:0] mag_q, src1_q, src2_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mag_q <= 4'h0;
         src1_q <= 4'h0;
         src2_q <= 4'h0;
      end else begin
         // RL9 shared magnitude, held off without reference
         mag_q <= ref_en ? exc1_q[chop_seq_pkg::MAG_LSB +: chop_seq_pkg::FIELD_W] : 4'h0;
         // RL10 independent routes
         src1_q <= exc2_q[chop_seq_pkg::SRC1_LSB +: chop_seq_pkg::FIELD_W];
         src2_q <= exc2_q[chop_seq_pkg::SRC2_LSB +: chop_seq_pkg::FIELD_W];
      end
   end

   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign chop_invert = pol_q;
   assign excitation_magnitude_field = mag_q;
   assign source1_route_field = src1_q;
   assign source2_route_field = src2_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_trig_restart: assert property (trigger && gchop |=> in_first && !pol_q) // RL15
      else $error("Trigger did not restart with normal polarity");
   a_first_swap: assert property (tmr_done && in_first && !trigger |=> pol_q && in_run) // RL6
      else $error("No swap after first data");
   a_run_swap: assert property (result_w && gchop |=> pol_q != $past(pol_q)) // RL5
      else $error("Polarity not reversed");
   a_avg_value: assert property (result_w && gchop |=> data_q == $past(avg_w)) // RL6
      else $error("Output word is not the average");
   a_chop_off: assert property (!gchop && result_w |=> !pol_q) // RL12
      else $error("Polarity swapped with chop disabled");
   a_mag_gate: assert property (!ref_en ##1 !ref_en |-> mag_q == 4'h0) // RL9
      else $error("Sources driven without reference");
   a_route_follow: assert property (##1 src2_q == $past(exc2_q[7:4])) // RL10
      else $error("Source two route stale");
   a_run_period: assert property ( // RL14
      result_w && cont && gchop |-> tmr_load && tmr_mods == CW'(half_w + dly_w + dly_w))
      else $error("Continuous period not reloaded");
   a_ready_set: assert property (result_w |=> ready_q) // RL7
      else $error("Result lost its ready flag");

   c_chop_start: cover property (trigger && gchop);
   c_avg_out: cover property (result_w && gchop && cont);
   c_read_data: cover property (data_read_q && ready_q);
endmodule

`default_nettype wire

// File: chop_seq_pkg.sv
// Shared constants, register map and conversion tables for the chop sequencer
package chop_seq_pkg;

   // ==========================================================
   // Register indexes (byte address is four times the index)
   localparam logic [7:0] IDX_GAIN = 8'h03;
   localparam logic [7:0] IDX_RATE = 8'h04;
   localparam logic [7:0] IDX_EXC1 = 8'h06;
   localparam logic [7:0] IDX_EXC2 = 8'h07;
   localparam logic [7:0] IDX_CTRL = 8'h08;
   localparam logic [7:0] IDX_STAT = 8'h09;
   localparam logic [7:0] IDX_DATA = 8'h0a;

   // ==========================================================
   // Field positions
   localparam int DELAY_LSB = 5;
   localparam int DELAY_W = 3;
   localparam int RATE_LSB = 0;
   localparam int RATE_W = 4;
   localparam int GCHOP_BIT = 4;
   localparam int CONT_BIT = 5;
   localparam int MAG_LSB = 0;
   localparam int SRC1_LSB = 0;
   localparam int SRC2_LSB = 4;
   localparam int FIELD_W = 4;
   localparam int REFEN_BIT = 0;
   localparam int SOFT_START_BIT = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_POL = 2;

   // ==========================================================
   // Reset values
   localparam logic [7:0] GAIN_RST = 8'h00;
   localparam logic [7:0] RATE_RST = 8'h34;
   localparam logic [7:0] EXC1_RST = 8'h00;
   localparam logic [7:0] EXC2_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // ==========================================================
   // Timing
   localparam int MOD_DIV = 16;
   localparam int CNT_W = 20;
   localparam int SAMPLE_W = 24;
   localparam logic [CNT_W-1:0] DELAY_BASE_MODS = 20'h0001c;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FIRST = 2'b01,
      ST_RUN = 2'b11
   } seq_state_t;

   // First global chop period in modulator periods, sinc3 filter
   function automatic logic [CNT_W-1:0] first_mods(input logic [RATE_W-1:0] code);
      case (code)
         4'h0: first_mods = 20'h96082;
         4'h1: first_mods = 20'h4b082;
         4'h2: first_mods = 20'h25882;
         4'h3: first_mods = 20'h16882;
         4'h4: first_mods = 20'h12c82;
         4'h5: first_mods = 20'h07882;
         4'h6: first_mods = 20'h06472;
         4'h7: first_mods = 20'h03c82;
         4'h8: first_mods = 20'h01e82;
         4'h9: first_mods = 20'h00f82;
         4'ha: first_mods = 20'h00802;
         4'hb: first_mods = 20'h00650;
         4'hc: first_mods = 20'h00350;
         default: first_mods = 20'h001d0;
      endcase
   endfunction

   // Settling delay in modulator periods; setting zero is the default
   function automatic logic [CNT_W-1:0] delay_mods(input logic [DELAY_W-1:0] code);
      delay_mods = DELAY_BASE_MODS << code;
   endfunction

endpackage

// File: conv_timer.sv
// Conversion period timer counting whole modulator periods
`timescale 1ns/1ps
`default_nettype none

module conv_timer #(
   parameter int MOD_DIV = chop_seq_pkg::MOD_DIV
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic load,
   input wire logic [chop_seq_pkg::CNT_W-1:0] load_mods,
   // Status
   output logic running,
   output logic done
);
   localparam logic [7:0] PRE_LAST = 8'(MOD_DIV - 1);
   localparam logic [chop_seq_pkg::CNT_W-1:0] ONE = 20'h00001;

   logic [7:0] pre_q;
   logic [chop_seq_pkg::CNT_W-1:0] remain_q;
   logic run_q;
   wire logic mod_tick = run_q && (pre_q == PRE_LAST);
   wire logic last_w = mod_tick && (remain_q == ONE);

   // ==========================================================
   // Prescaler and period counter
   // RL2 one modulator period is sixteen master clocks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q <= 8'h00;
         remain_q <= '0;
         run_q <= 1'b0;
      end else begin
         if (load) begin
            pre_q <= 8'h00;
            remain_q <= (load_mods == '0) ? ONE : load_mods;
            run_q <= 1'b1;
         end else if (mod_tick) begin
            pre_q <= 8'h00;
            remain_q <= remain_q - ONE;
            run_q <= !last_w;
         end else if (run_q) begin
            pre_q <= pre_q + 8'h01;
         end
      end
   end

   assign running = run_q;
   // Done marks the last cycle so a reload lands on the period boundary
   assign done = last_w;

   // ==========================================================
   // Checks
   int unsigned cyc_q;
   int unsigned want_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cyc_q <= 0;
         want_q <= 0;
      end else if (load) begin
         cyc_q <= 0;
         want_q <= ((load_mods == '0) ? 1 : int'(load_mods)) * MOD_DIV;
      end else begin
         cyc_q <= cyc_q + 1;
      end
   end

   a_period_length: assert property ( // RL1
      @(posedge aclk) disable iff (!aresetn) done && !load |-> cyc_q + 1 == want_q)
      else $error("Conversion period has wrong length");
   a_clock_scale: assert property ( // RL2
      @(posedge aclk) disable iff (!aresetn) mod_tick |=> pre_q == 8'h00)
      else $error("Modulator prescaler did not wrap");
   c_period_done: cover property (@(posedge aclk) disable iff (!aresetn) done);
endmodule

`default_nettype wire

// File: trigger_capture.sv
// Start pin and serial start command capture with clock crossing
`timescale 1ns/1ps
`default_nettype none

module trigger_capture #(
   parameter logic [7:0] START_OPCODE = 8'h08
) (
   // System clock domain
   input wire logic aclk,
   input wire logic aresetn,
   // Link pins
   input wire logic start_pin,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   // Trigger out
   output logic trigger
);
   localparam logic [2:0] SEVENTH = 3'h6;

   // ==========================================================
   // Link domain, falling serial clock edges
   // Frame select high clears the link logic; clock may stop between frames
   logic [2:0] edge_cnt_q;
   logic [5:0] shift_q;
   logic cmd_seen_q;
   wire logic [6:0] head_w = {shift_q, sdi};

   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         edge_cnt_q <= 3'h0;
         shift_q <= 6'h00;
         cmd_seen_q <= 1'b0;
      end else begin
         shift_q <= head_w[5:0];
         if (edge_cnt_q != 3'h7) begin
            edge_cnt_q <= edge_cnt_q + 3'h1;
         end
         // RL3 seventh falling edge
         if (edge_cnt_q == SEVENTH && head_w == START_OPCODE[7:1]) begin
            cmd_seen_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // System domain synchronisers
   logic [2:0] cmd_sync_q;
   logic [2:0] pin_sync_q;
   logic trig_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_sync_q <= 3'b000;
         pin_sync_q <= 3'b000;
         trig_q <= 1'b0;
      end else begin
         cmd_sync_q <= {cmd_sync_q[1:0], cmd_seen_q};
         pin_sync_q <= {pin_sync_q[1:0], start_pin};
         // RL3 pin rise or command
         trig_q <= (cmd_sync_q[1] && !cmd_sync_q[2]) || (pin_sync_q[1] && !pin_sync_q[2]);
      end
   end

   assign trigger = trig_q;

   a_cmd_seventh: assert property ( // RL3
      @(negedge sclk) disable iff (cs_n) $rose(cmd_seen_q) |-> $past(edge_cnt_q) == SEVENTH)
      else $error("Start command seen on the wrong clock edge");
   c_cmd_trigger: cover property (@(posedge aclk) disable iff (!aresetn) $rose(cmd_sync_q[2]));
endmodule

`default_nettype wire

// File: chop_host_model.sv
// Host model driving the start pin and serial start frames
`timescale 1ns/1ps
`default_nettype none

module chop_host_model #(
   parameter logic [7:0] OPC = 8'h08
) (
   // Requests
   input wire logic pin_req,
   input wire logic cmd_req,
   // Link pins
   output logic start_pin,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   // ==========================================
   // Link drive
   initial begin
      start_pin = 0;
      sclk = 0;
      cs_n = 1;
      sdi = 0;
   end
   always @(posedge pin_req) begin
      start_pin = 1;
      #100 start_pin = 0;
   end
   always @(posedge cmd_req) begin
      #3 cs_n = 0;
      for (int i = 7; i >= 0; i--) begin
         // Data moves on the rising edge so it is settled at the falling one
         #32 sclk = 1;
         sdi = OPC[i];
         #32 sclk = 0;
      end
      #32 cs_n = 1;
      // Released line must not keep its last bit
      sdi = ~sdi;
   end
endmodule
`default_nettype wire

// File: global_chop_conversion_sequencer_bench.sv
// Self-checking bench for the global chop sequencer
`timescale 1ns/1ps
`default_nettype none

module global_chop_conversion_sequencer_bench;
   // ==========================================
   // Signals
   logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, pq = 0, cq = 0;
   logic awr, wry, bv, arr, rv, ci, sp, sck, csn, sdi;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdd, d, m;
   logic [1:0] br, rr, r;
   logic [3:0] mag, s1, s2;
   logic [23:0] fs = 0, sa = 0, sb = 0;
   logic [2:0] dl;
   int bad_count = 0, compares = 0, cyc = 0, n;
   // Rate code 10 first count 2050 >> 8 is 8, half of it 4
   localparam int H = 4;

   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) fs <= ci ? sb : sa;
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end

   chop_sequencer #(.COUNT_SHIFT(8)) uut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wry), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .start_pin(sp), .sclk(sck), .cs_n(csn), .sdi(sdi),
      .filter_sample(fs), .chop_invert(ci), .excitation_magnitude_field(mag),
      .source1_route_field(s1), .source2_route_field(s2));
   chop_host_model host (.pin_req(pq), .cmd_req(cq), .start_pin(sp), .sclk(sck),
      .cs_n(csn), .sdi(sdi));

   // ==========================================
   // Tasks
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awa <= a;
      wd <= v;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wry) wv <= 0;
      end while (bv !== 1);
      rs = br;
      bry <= 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (rv !== 1);
      v = rdd;
      rs = rr;
      rry <= 0;
   endtask
   // Counts cycles until the polarity output reaches v
   task automatic wait_pol(input logic v);
      n = 0;
      while (ci !== v) begin
         @(negedge aclk);
         n++;
      end
   endtask
   function automatic int per(input logic [2:0] c, input int k);
      return (H + k * (28 << c)) * 16;
   endfunction
   function automatic logic [31:0] avg(input logic [23:0] a, input logic [23:0] b);
      logic signed [24:0] t;
      t = $signed({a[23], a}) - $signed({b[23], b});
      return {{8{t[24]}}, t[24:1]};
   endfunction
   // Narrow range keeps the difference inside the sample width
   function automatic logic [23:0] rnd();
      logic [21:0] x;
      x = 22'($urandom);
      return {{2{x[21]}}, x};
   endfunction
   task automatic report_and_stop();
      if (bad_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================
   // Sequence
   initial begin
      logic [7:0] ix [5];
      ix = '{8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20};
      void'($urandom(32'h1a93a560));
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 5; i++) begin
         rd(ix[i], d, r);
         chk("reset value", d, i == 1 ? 32'h34 : 32'h0);
      end
      rd(8'h3c, d, r);
      chk("unmapped rresp", 32'(r), 32'h2);
      chk("unmapped rdata", d, 32'h0);
      wr(8'h3c, 32'h0, r);
      chk("unmapped bresp", 32'(r), 32'h2);
      m = $urandom;
      wr(8'h18, m, r);
      wr(8'h1c, m >> 8, r);
      chk("magnitude off", 32'(mag), 32'h0);
      wr(8'h20, 32'h1, r);
      @(negedge aclk);
      chk("magnitude", 32'(mag), 32'(m[3:0]));
      chk("routes", 32'({s2, s1}), 32'(m[15:8]));
      dl = 3'($urandom % 3);
      wr(8'h0c, 32'(dl) << 5, r);
      sa = rnd();
      sb = rnd();
      wr(8'h10, 32'h3a, r);
      wr(8'h20, 32'h3, r);
      wait_pol(1);
      wait_pol(0);
      chk("second half", 32'(n), 32'(per(dl, 1)));
      wait_pol(1);
      chk("cont period", 32'(n), 32'(per(dl, 2)));
      rd(8'h24, d, r);
      chk("status", d & 32'h6, 32'h6);
      rd(8'h28, d, r);
      chk("average", d, avg(sa, sb));
      for (int k = 0; k < 2; k++) begin
         wait_pol(1);
         sa = rnd();
         sb = rnd();
         if (k == 0) pq <= 1;
         else cq <= 1;
         @(posedge aclk);
         pq <= 0;
         cq <= 0;
         wait_pol(0);
         chk("restart", 32'(n < 300), 32'h1);
         wait_pol(1);
         wait_pol(0);
         chk("restart half", 32'(n), 32'(per(dl, 1)));
         rd(8'h28, d, r);
         chk("restart avg", d, avg(sa, sb));
      end
      wr(8'h10, 32'h0a, r);
      wr(8'h20, 32'h3, r);
      repeat (per(dl, 1) + 40) @(negedge aclk);
      chk("no chop pol", 32'(ci), 32'h0);
      rd(8'h28, d, r);
      chk("raw result", d, {{8{sa[23]}}, sa});
      report_and_stop();
   end
endmodule
`default_nettype wire
